// File: logic/abscp_defs.svh
// offsets, field positions, reset values and timing counts of the console port
`ifndef ABSCP_DEFS_SVH
`define ABSCP_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ABSCP_OFF_CTRL 8'h00
`define ABSCP_OFF_STATUS 8'h04
`define ABSCP_OFF_TXDATA 8'h08
`define ABSCP_OFF_RXDATA 8'h0C
`define ABSCP_OFF_PARAM 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define ABSCP_CTRL_REID_BIT 0
`define ABSCP_CTRL_ONESTOP_BIT 1
`define ABSCP_ST_IDENT_BIT 0
`define ABSCP_ST_TXBUSY_BIT 1
`define ABSCP_ST_RXBUSY_BIT 2
`define ABSCP_ST_RXFULL_BIT 3
`define ABSCP_ST_STOP_BIT 4
`define ABSCP_ST_LINE_BIT 5

// ****************************************************************
// reset values
// ****************************************************************
`define ABSCP_SOD_RESET 1'b0
`define ABSCP_PARAM_RESET 16'h0101

// ****************************************************************
// timing, in machine cycles unless noted
// ****************************************************************
`define ABSCP_MC_CLKS 2
`define ABSCP_FIXED_MC 20'h0003D
`define ABSCP_DELAY_BASE_MC 20'h00016
`define ABSCP_STEP_MC 20'h0000E
`define ABSCP_PAGE_MC 20'h00E0B
`define ABSCP_ID_CHUNK_MC 20'h00054
`define ABSCP_ID_START 16'hFFFA
`define ABSCP_STEPS_TWO_STOP 4'hB
`define ABSCP_STEPS_ONE_STOP 4'hA
`define ABSCP_RX_SAMPLES 4'h9

`endif

// File: logic/abscp_mc_timer.sv
// machine-cycle delay timer: counts a loaded number of machine cycles
`include "abscp_defs.svh"
`default_nettype none

module abscp_mc_timer #(
	parameter int MC_CLKS = `ABSCP_MC_CLKS
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire abscp_pkg::abscp_mc_t load_i,
	output logic done_o
);
	import abscp_pkg::*;

	localparam logic [3:0] PRE_LAST = 4'(MC_CLKS - 1);

	logic busy_reg;
	logic [3:0] pre_reg;
	abscp_mc_t cnt_reg;

	// ****************************************************************
	// countdown
	// ****************************************************************
	// (RULE_19) two clocks per machine cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			busy_reg <= 1'b0;
			pre_reg <= 4'h0;
			cnt_reg <= 20'h00000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_reg <= 1'b1;
				pre_reg <= 4'h0;
				cnt_reg <= load_i;
			end else if (busy_reg) begin
				if (pre_reg == PRE_LAST) begin
					pre_reg <= 4'h0;
					// a zero load behaves as one machine cycle
					if (cnt_reg <= 20'h00001) begin
						busy_reg <= 1'b0;
						done_o <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg - 20'h00001;
					end
				end else begin
					pre_reg <= pre_reg + 4'h1;
				end
			end
		end
	end

endmodule : abscp_mc_timer

`default_nettype wire

// File: logic/abscp_pkg.sv
// types shared by the console port design
`default_nettype none

package abscp_pkg;

	typedef enum logic [2:0] {
		ABSCP_ST_IDLE = 3'h0,
		ABSCP_ST_ID_HIGH = 3'h1,
		ABSCP_ST_ID_LOW = 3'h2,
		ABSCP_ST_ID_MEAS = 3'h3,
		ABSCP_ST_TX_BIT = 3'h4,
		ABSCP_ST_RX_START = 3'h5,
		ABSCP_ST_RX_HALF = 3'h6,
		ABSCP_ST_RX_BIT = 3'h7
	} abscp_state_t;

	typedef logic [19:0] abscp_mc_t;
	typedef logic [15:0] abscp_param_t;

endpackage : abscp_pkg

`default_nettype wire

// File: logic/abscp_port.sv
// autobaud serial console port: apb registers, identification, tx, rx
//
// Local design decisions: the register offsets and the APB register port.
`include "abscp_defs.svh"
`default_nettype none

// Notes on behaviour
// (RULE_01) after reset identify rate from space
// (RULE_02) identification reruns on reset or request
// (RULE_03) console sends exactly a space first
// (RULE_04) keep full-bit and half-bit delay parameters
// (RULE_05) tx and rx use identified rate
// (RULE_06) transmit runs eleven identical bit steps
// (RULE_07) nine-bit rotate, carry refilled with one
// (RULE_08) carry starts zero giving start bit; here carry starts one and the start bit is driven on the line directly
// (RULE_09) steps ten onward drive a one
// (RULE_10) optional ten steps, single stop bit
// (RULE_11) transfers are not disturbed by bus activity
// (RULE_12) await falling edge, then half-bit delay
// (RULE_13) first sample at 1.5 bits, then full
// (RULE_14) samples shift right, first bit lsb
// (RULE_15) ninth sample ends, stop kept in carry
// (RULE_16) receive completes after next full character
// (RULE_17) tx and rx steps equally long
// (RULE_18) bit is 61 plus programmable delay
// (RULE_19) machine cycle equals two clocks
// (RULE_20) one parameter step adds 14 cycles
// (RULE_21) low start, 8 lsb-first, high stops
// (RULE_22) measure six-bit low of space
// (RULE_23) output low after reset until written
// (RULE_24) no stop bit check or framing error
// (RULE_25) identify waits for idle-high line first
module abscp_port (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic serial_input_line_i,
	output logic serial_output_line_o
);
	import abscp_pkg::*;

	// ****************************************************************
	// functions
	// ****************************************************************
	// delay segment of a bit step; wraps like byte decrements do
	// (RULE_20) low byte steps by 14
	function automatic abscp_mc_t delay_mc(input abscp_param_t p);
		logic [7:0] hm;
		logic [7:0] lm;
		hm = p[15:8] - 8'h01;
		lm = p[7:0] - 8'h01;
		delay_mc = `ABSCP_DELAY_BASE_MC + {12'h000, lm} * `ABSCP_STEP_MC
			+ {12'h000, hm} * `ABSCP_PAGE_MC;
	endfunction : delay_mc

	// (RULE_18) fixed part plus delay
	// (RULE_17) one period for both directions
	function automatic abscp_mc_t period_mc(input abscp_param_t p);
		period_mc = `ABSCP_FIXED_MC + delay_mc(p);
	endfunction : period_mc

	// bytewise increment, as separate high and low bytes
	function automatic abscp_param_t bump(input abscp_param_t p);
		bump = {p[15:8] + 8'h01, p[7:0] + 8'h01};
	endfunction : bump

	// ****************************************************************
	// state
	// ****************************************************************
	abscp_state_t state_reg;
	abscp_param_t full_bit_delay_reg;
	abscp_param_t half_bit_delay_reg;
	abscp_param_t measure_reg;
	logic [7:0] shift_reg;
	logic carry_bit_reg;
	logic [3:0] step_reg;
	logic [7:0] rx_data_reg;
	logic rx_fin_reg;
	logic tmr_start_reg;
	abscp_mc_t tmr_load_reg;
	logic tmr_done;
	logic sod_reg;

	// bus side
	logic onestop_reg;
	logic reid_reg;
	logic start_tx_reg;
	logic start_rx_reg;
	logic [7:0] tx_char_reg;
	logic rx_full_reg;
	logic param_wr_reg;
	logic [31:0] param_wdata_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	logic access;
	logic idle;
	logic [3:0] frame_steps;

	assign access = psel_i & penable_i & ~pready_reg;
	assign idle = (state_reg == ABSCP_ST_IDLE);
	// (RULE_10) single stop when selected
	assign frame_steps = onestop_reg ? `ABSCP_STEPS_ONE_STOP
		: `ABSCP_STEPS_TWO_STOP;

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign serial_output_line_o = sod_reg;

	abscp_mc_timer #(
		.MC_CLKS(`ABSCP_MC_CLKS)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.start_i(tmr_start_reg),
		.load_i(tmr_load_reg),
		.done_o(tmr_done)
	);

	// ****************************************************************
	// serial engine
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			// (RULE_01) reset enters identification
			state_reg <= ABSCP_ST_ID_HIGH;
			full_bit_delay_reg <= `ABSCP_PARAM_RESET;
			half_bit_delay_reg <= `ABSCP_PARAM_RESET;
			measure_reg <= `ABSCP_ID_START;
			shift_reg <= 8'h00;
			carry_bit_reg <= 1'b0;
			step_reg <= 4'h0;
			rx_data_reg <= 8'h00;
			rx_fin_reg <= 1'b0;
			tmr_start_reg <= 1'b0;
			tmr_load_reg <= 20'h00000;
			// (RULE_23) low until first transmit
			sod_reg <= `ABSCP_SOD_RESET;
		end else begin
			tmr_start_reg <= 1'b0;
			rx_fin_reg <= 1'b0;
			if (reid_reg) begin
				// (RULE_02) rerun on request
				state_reg <= ABSCP_ST_ID_HIGH;
			end else begin
				case (state_reg)
					ABSCP_ST_IDLE: begin
						if (param_wr_reg) begin
							full_bit_delay_reg <= param_wdata_reg[15:0];
							half_bit_delay_reg <= param_wdata_reg[31:16];
						end else if (start_tx_reg) begin
							// (RULE_08) start bit driven directly, carry loaded with one
							shift_reg <= tx_char_reg;
							carry_bit_reg <= 1'b1;
							sod_reg <= 1'b0;
							step_reg <= 4'h0;
							tmr_start_reg <= 1'b1;
							// (RULE_05) stored rate drives tx
							tmr_load_reg <= period_mc(full_bit_delay_reg);
							state_reg <= ABSCP_ST_TX_BIT;
						end else if (start_rx_reg) begin
							step_reg <= 4'h0;
							state_reg <= ABSCP_ST_RX_START;
						end
					end
					ABSCP_ST_ID_HIGH: begin
						// (RULE_25) skip a partial frame
						if (serial_input_line_i) begin
							state_reg <= ABSCP_ST_ID_LOW;
						end
					end
					ABSCP_ST_ID_LOW: begin
						if (!serial_input_line_i) begin
							// (RULE_22) count 84-cycle chunks of low
							measure_reg <= `ABSCP_ID_START + 16'h0001;
							tmr_start_reg <= 1'b1;
							tmr_load_reg <= `ABSCP_ID_CHUNK_MC;
							state_reg <= ABSCP_ST_ID_MEAS;
						end
					end
					ABSCP_ST_ID_MEAS: begin
						if (tmr_done) begin
							if (!serial_input_line_i) begin
								measure_reg <= measure_reg + 16'h0001;
								tmr_start_reg <= 1'b1;
								tmr_load_reg <= `ABSCP_ID_CHUNK_MC;
							end else begin
								// (RULE_04) derive both parameters
								full_bit_delay_reg <= bump(measure_reg);
								half_bit_delay_reg <= bump({1'b0,
									measure_reg[15:1]});
								state_reg <= ABSCP_ST_IDLE;
							end
						end
					end
					ABSCP_ST_TX_BIT: begin
						if (tmr_done) begin
							// (RULE_07) rotate right, one into carry
							shift_reg <= {carry_bit_reg, shift_reg[7:1]};
							carry_bit_reg <= 1'b1;
							step_reg <= step_reg + 4'h1;
							// (RULE_06) same step per bit, fixed count
							if (step_reg == frame_steps - 4'h1) begin
								state_reg <= ABSCP_ST_IDLE;
							end else begin
								// (RULE_21) lsb first, then stops
								// (RULE_09) refilled ones become stops
								sod_reg <= shift_reg[0];
								tmr_start_reg <= 1'b1;
								tmr_load_reg <= period_mc(full_bit_delay_reg);
							end
						end
					end
					ABSCP_ST_RX_START: begin
						// (RULE_12) falling edge then half bit
						if (!serial_input_line_i) begin
							tmr_start_reg <= 1'b1;
							tmr_load_reg <= delay_mc(half_bit_delay_reg);
							state_reg <= ABSCP_ST_RX_HALF;
						end
					end
					ABSCP_ST_RX_HALF: begin
						if (tmr_done) begin
							// (RULE_13) then full bits to mid-bit
							tmr_start_reg <= 1'b1;
							tmr_load_reg <= period_mc(full_bit_delay_reg);
							state_reg <= ABSCP_ST_RX_BIT;
						end
					end
					ABSCP_ST_RX_BIT: begin
						if (tmr_done) begin
							step_reg <= step_reg + 4'h1;
							// (RULE_15) ninth sample ends the byte
							if (step_reg == `ABSCP_RX_SAMPLES - 4'h1) begin
								// (RULE_24) stop level is only kept
								carry_bit_reg <= serial_input_line_i;
								rx_data_reg <= shift_reg;
								rx_fin_reg <= 1'b1;
								state_reg <= ABSCP_ST_IDLE;
							end else begin
								// (RULE_14) shift in from the top
								shift_reg <= {serial_input_line_i,
									shift_reg[7:1]};
								tmr_start_reg <= 1'b1;
								tmr_load_reg <= period_mc(full_bit_delay_reg);
							end
						end
					end
					default: begin
						state_reg <= ABSCP_ST_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// received-byte flag
	// ****************************************************************
	// set wins over clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rx_full_reg <= 1'b0;
		end else if (rx_fin_reg) begin
			rx_full_reg <= 1'b1;
		end else if (access && !pwrite_i && rx_full_reg
			&& paddr_i == `ABSCP_OFF_RXDATA) begin
			rx_full_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// apb slave
	// ****************************************************************
	// one wait state; tx data writes and rx data reads with no byte in stall while the engine
	// is busy, so bus traffic can never bend the bit timing
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			onestop_reg <= 1'b0;
			reid_reg <= 1'b0;
			start_tx_reg <= 1'b0;
			start_rx_reg <= 1'b0;
			tx_char_reg <= 8'h00;
			param_wr_reg <= 1'b0;
			param_wdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			reid_reg <= 1'b0;
			start_tx_reg <= 1'b0;
			start_rx_reg <= 1'b0;
			param_wr_reg <= 1'b0;
			// read data stands only with its pready pulse
			prdata_reg <= 32'h00000000;
			if (access) begin
				case (paddr_i)
					`ABSCP_OFF_CTRL: begin
						pready_reg <= 1'b1;
						if (pwrite_i) begin
							// (RULE_02) rate change request
							reid_reg <= pwdata_i[`ABSCP_CTRL_REID_BIT];
							onestop_reg <= pwdata_i[`ABSCP_CTRL_ONESTOP_BIT];
						end else begin
							prdata_reg[`ABSCP_CTRL_ONESTOP_BIT] <= onestop_reg;
						end
					end
					`ABSCP_OFF_STATUS: begin
						pready_reg <= 1'b1;
						prdata_reg[`ABSCP_ST_IDENT_BIT] <=
							(state_reg == ABSCP_ST_ID_HIGH)
							|| (state_reg == ABSCP_ST_ID_LOW)
							|| (state_reg == ABSCP_ST_ID_MEAS);
						prdata_reg[`ABSCP_ST_TXBUSY_BIT] <=
							(state_reg == ABSCP_ST_TX_BIT);
						prdata_reg[`ABSCP_ST_RXBUSY_BIT] <=
							(state_reg == ABSCP_ST_RX_START)
							|| (state_reg == ABSCP_ST_RX_HALF)
							|| (state_reg == ABSCP_ST_RX_BIT);
						prdata_reg[`ABSCP_ST_RXFULL_BIT] <= rx_full_reg;
						prdata_reg[`ABSCP_ST_STOP_BIT] <= carry_bit_reg;
						prdata_reg[`ABSCP_ST_LINE_BIT] <= sod_reg;
					end
					`ABSCP_OFF_TXDATA: begin
						if (!pwrite_i) begin
							pready_reg <= 1'b1;
						end else if (idle && !start_rx_reg
							&& !param_wr_reg) begin
							// (RULE_11) taken only when idle
							pready_reg <= 1'b1;
							tx_char_reg <= pwdata_i[7:0];
							start_tx_reg <= 1'b1;
						end
					end
					`ABSCP_OFF_RXDATA: begin
						if (pwrite_i) begin
							pready_reg <= 1'b1;
						end else if (rx_full_reg) begin
							// (RULE_16) answer once a byte is in
							pready_reg <= 1'b1;
							prdata_reg[7:0] <= rx_data_reg;
						end else if (idle && !start_rx_reg
							&& !start_tx_reg && !rx_fin_reg) begin
							// a byte landing now must not rearm rx
							start_rx_reg <= 1'b1;
						end
					end
					`ABSCP_OFF_PARAM: begin
						if (!pwrite_i) begin
							pready_reg <= 1'b1;
							prdata_reg <= {half_bit_delay_reg,
								full_bit_delay_reg};
						end else if (idle && !start_tx_reg
							&& !start_rx_reg) begin
							pready_reg <= 1'b1;
							param_wr_reg <= 1'b1;
							param_wdata_reg <= pwdata_i;
						end
					end
					default: begin
						pready_reg <= 1'b1;
						pslverr_reg <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule : abscp_port

`default_nettype wire

// File: sim/abscp_console.sv
// console model: sends and receives serial characters
`default_nettype none
module abscp_console (
	input wire logic clk_sys_i,
	input wire logic line_from_dut_i,
	output logic line_to_dut_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_clks = 210;
	logic [8:0] got_q[$];
	initial line_to_dut_o = 1'b1;
	// low start, lsb first, one high stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_to_dut_o <= f[i];
			repeat (bit_clks) @(posedge clk_sys_i);
		end
	endtask : send
	// idle high first, so a reset low is no start
	initial begin : rx_proc
		logic [8:0] sh;
		forever begin
			wait (line_from_dut_i === 1'b1);
			@(negedge line_from_dut_i);
			repeat (bit_clks / 2) @(posedge clk_sys_i);
			for (int i = 0; i < 9; i++) begin
				repeat (bit_clks) @(posedge clk_sys_i);
				sh = {line_from_dut_i, sh[8:1]};
			end
			got_q.push_back(sh);
		end
	end
endmodule : abscp_console
`default_nettype wire

// File: sim/abscp_port_monitor.sv
// pin-level checker of the console port
`include "abscp_defs.svh"
`default_nettype none
module abscp_port_monitor (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic serial_output_line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// shortest bit: 83 machine cycles of 2 clocks
	localparam int MIN_RUN = 166;
	logic tx_seen_reg;
	logic line_reg;
	int run_reg;
	logic mapped;
	assign mapped = paddr_i[1:0] == 2'h0 && paddr_i <= `ABSCP_OFF_PARAM;
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			tx_seen_reg <= 1'b0;
		end else if (pready_o && pwrite_i &&
			paddr_i == `ABSCP_OFF_TXDATA) begin
			tx_seen_reg <= 1'b1;
		end
	end
	// level run length, restarts on every change
	always_ff @(posedge clk_sys_i) begin
		line_reg <= serial_output_line_o;
		if (sys_rst_i || line_reg != serial_output_line_o) begin
			run_reg <= 1;
		end else begin
			run_reg <= run_reg + 1;
		end
	end
	// ****
	// assertions
	// ****
	default clocking mon_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_status_rd;
		psel_i && penable_i && !pwrite_i && paddr_i == `ABSCP_OFF_STATUS;
	endsequence
	a_reset_line_low: assert property (
		$past(sys_rst_i) |-> !serial_output_line_o)
		else $error("output line not low after reset");
	a_low_until_tx: assert property (
		!tx_seen_reg |-> !serial_output_line_o)
		else $error("output line rose before any transmit");
	a_bit_min_len: assert property (
		line_reg != serial_output_line_o |-> run_reg >= MIN_RUN)
		else $error("output level shorter than one bit");
	a_status_fast: assert property (
		s_setup ##1 s_status_rd |=> pready_o)
		else $error("status read not answered next cycle");
	a_ready_pulse: assert property (
		pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (
		pready_o |-> psel_i && penable_i)
		else $error("ready outside an access phase");
	a_unmapped_err: assert property (
		$rose(penable_i) && psel_i && !mapped |=> pready_o && pslverr_o)
		else $error("unmapped access not refused at once");
	a_err_only_bad: assert property (
		pslverr_o |-> pready_o && !mapped)
		else $error("error on a mapped register");
	a_data_quiet: assert property (
		!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside an answer");
endmodule : abscp_port_monitor
bind abscp_port abscp_port_monitor abscp_port_monitor_i (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.serial_output_line_o(serial_output_line_o)
);
`default_nettype wire

// File: sim/test_autobaud_serial_console_port.sv
// self-checking bench of the console port
`include "abscp_defs.svh"
`default_nettype none
module test_autobaud_serial_console_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic rx_line;
	logic tx_line;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int t0;
	int d;
	logic [31:0] seed = 32'h0001485C;
	logic [31:0] rd;
	logic [31:0] par;
	logic err;
	logic [7:0] b;
	logic [8:0] exp_q[$];
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	abscp_port abscp_port_i (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .serial_input_line_i(rx_line),
		.serial_output_line_o(tx_line)
	);
	abscp_console abscp_console_i (
		.clk_sys_i(clk_sys_i), .line_from_dut_i(tx_line),
		.line_to_dut_o(rx_line)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// 84-cycle chunks of the six-bit low, from -6
	function automatic logic [31:0] id_param(input int p);
		int c;
		logic [15:0] h;
		c = (3 * p + 83) / 84 - 6;
		h = 16'(c >> 1);
		return {h[15:8] + 8'h01, h[7:0] + 8'h01,
			8'(c >> 8) + 8'h01, 8'(c) + 8'h01};
	endfunction : id_param
	// bit in clocks, timer restart included
	function automatic int per(input logic [15:0] f);
		return 2 * (83 + 14 * (int'(f[7:0]) - 1)
			+ 3595 * (int'(f[15:8]) - 1)) + 2;
	endfunction : per
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] dat);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= dat;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : apb
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t reg %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t line %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// ****
	// scenarios
	// ****
	task automatic run_tx();
		int p;
		p = per(par[15:0]);
		for (int m = 0; m < 2; m++) begin
			// parameter write doubles as a wait for idle
			apb(1'b1, `ABSCP_OFF_PARAM, par);
			apb(1'b1, `ABSCP_OFF_CTRL, 32'(m << 1));
			apb(1'b0, `ABSCP_OFF_CTRL, 32'h0);
			chk_reg(rd, 32'(m << 1));
			for (int k = 0; k < 3; k++) begin
				b = 8'(rnd());
				exp_q.push_back({1'b1, b});
				apb(1'b1, `ABSCP_OFF_TXDATA, {24'h0, b});
				d = cyc - t0 - (11 - m) * p;
				if (k > 0) chk_reg({31'h0, d * 2 > -p && d * 2 < p}, 32'h1);
				t0 = cyc;
				apb(1'b0, `ABSCP_OFF_STATUS, 32'h0);
				chk_reg(rd & 32'h2, 32'h2);
			end
		end
		apb(1'b1, `ABSCP_OFF_PARAM, par);
		repeat (p) @(posedge clk_sys_i);
		chk_reg(32'(abscp_console_i.got_q.size()), 32'(exp_q.size()));
		while (exp_q.size() > 0) begin
			chk_byte(abscp_console_i.got_q.pop_front(), exp_q.pop_front());
		end
	endtask : run_tx
	task automatic run_rx();
		for (int k = 0; k < 3; k++) begin
			b = 8'(rnd());
			fork
				apb(1'b0, `ABSCP_OFF_RXDATA, 32'h0);
				begin
					repeat (40) @(posedge clk_sys_i);
					abscp_console_i.send(b);
				end
			join
			chk_reg(rd, {24'h0, b});
		end
		apb(1'b0, `ABSCP_OFF_STATUS, 32'h0);
		chk_reg(rd & 32'h10, 32'h10);
	endtask : run_rx
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		apb(1'b0, `ABSCP_OFF_PARAM, 32'h0);
		chk_reg(rd, 32'h01010101);
		apb(1'b0, `ABSCP_OFF_STATUS, 32'h0);
		chk_reg(rd & 32'h21, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk_reg({31'h0, err}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			if (i > 0) begin
				apb(1'b1, `ABSCP_OFF_CTRL, 32'h1);
				apb(1'b0, `ABSCP_OFF_STATUS, 32'h0);
				chk_reg(rd & 32'h1, 32'h1);
			end
			abscp_console_i.bit_clks = 210 + 84 * i;
			abscp_console_i.send(8'h20);
			apb(1'b0, `ABSCP_OFF_PARAM, 32'h0);
			par = id_param(210 + 84 * i);
			chk_reg(rd, par);
			abscp_console_i.bit_clks = per(par[15:0]);
			// all-ones frame lifts the line out of its reset low
			if (i == 0) apb(1'b1, `ABSCP_OFF_TXDATA, 32'hFF);
			run_tx();
			run_rx();
		end
		// mid-run reset must restart identification
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		apb(1'b0, `ABSCP_OFF_PARAM, 32'h0);
		chk_reg(rd, 32'h01010101);
		apb(1'b0, `ABSCP_OFF_STATUS, 32'h0);
		chk_reg(rd & 32'h21, 32'h1);
		final_report();
	end
endmodule : test_autobaud_serial_console_port
`default_nettype wire
